// *** rtl/hwmr_defines.vh ***
// register offsets, reset values and timing constants for the monitor reading block
`ifndef HWMR_DEFINES_VH
`define HWMR_DEFINES_VH
`define HWMR_ZONE1_TEMP 8'h25
`define HWMR_ZONE2_TEMP 8'h26
`define HWMR_ZONE3_TEMP 8'h27
`define HWMR_FAN1_LOW 8'h28
`define HWMR_FAN1_HIGH 8'h29
`define HWMR_FAN2_LOW 8'h2A
`define HWMR_FAN2_HIGH 8'h2B
`define HWMR_FAN3_LOW 8'h2C
`define HWMR_FAN3_HIGH 8'h2D
`define HWMR_PWM2_DUTY 8'h31
`define HWMR_FAN_LAST 8'h2D
`define HWMR_PWM1_DUTY 8'h30
`define HWMR_PWM3_DUTY 8'h32
`define HWMR_LOWBITS1 8'h85
`define HWMR_LOWBITS2 8'h86
`define HWMR_CTRL 8'h40
`define HWMR_FAN_MODE 8'h41
`define HWMR_TEMP_FAULT 8'h80
`define HWMR_ALL_ONES8 8'hFF
`define HWMR_ALL_ONES16 16'hFFFF
`define HWMR_CLK_HZ 125000000
`define HWMR_TICK_HZ 90000
`define HWMR_TICK_DIV (`HWMR_CLK_HZ / `HWMR_TICK_HZ)
`define HWMR_REFRESH_HZ 4
`define HWMR_REFRESH_CYC (`HWMR_CLK_HZ / `HWMR_REFRESH_HZ)
`define HWMR_TACH_UPD_S 1
`define HWMR_TACH_UPD_CYC (`HWMR_CLK_HZ * `HWMR_TACH_UPD_S)
`define HWMR_PWM_STEPS 8'hFF
`endif

// *** rtl/hwmr_reading_regs.v ***
// reading registers of the hardware monitor: temperatures, fan periods, pwm duty
//
// Summary of operation
// - temperature register holds top 8 of 12 bits
// - absent or faulty diode reads 80h
// - temperatures refresh at least four times per second
// - writes to temperature registers are ignored
// - zones: remote one, ambient, remote two
// - four extra precision bits in low-bit registers
// - sixteen-bit count of 90 kHz ticks per revolution
// - two tach pulses make one revolution
// - tach registers update within one second
// - tach registers go all ones on power good
// - tach measures regardless of start or fan state
// - reading one tach byte freezes the other byte
// - stopped, invalid or overflow reads all ones
// - duty writes accepted whenever unlocked, in any mode
// - after power-on duty is full, reads FFh
// - started and automatic: duty from fan algorithm
// - early writes held in shadow, read FFh
// - duty is linear eight-bit value
// - spin-up reports duty as zero
// - readback duty copied at pwm period start
// - start clear: 255 clocks high, 1 low
//
// The Wishbone interface to the registers was chosen for this implementation.
`default_nettype none
`include "hwmr_defines.vh"
module hwmr_reading_regs #(
  parameter REFRESH_CYC = `HWMR_REFRESH_CYC,
  parameter TACH_UPD_CYC = `HWMR_TACH_UPD_CYC,
  parameter TICK_DIV = `HWMR_TICK_DIV
) (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [11:0] first_remote_reading,
  input wire [11:0] ambient_reading,
  input wire [11:0] second_remote_reading,
  input wire first_diode_fault,
  input wire second_diode_fault,
  input wire [2:0] tach_in,
  input wire main_power_good,
  input wire [2:0] manual_mode,
  input wire [2:0] ramp_enable,
  input wire start,
  input wire lock,
  input wire [23:0] auto_duty,
  input wire [2:0] spin_up,
  output wire [2:0] pwm_out
);
  // ----------------------------------------
  // temperature sampling
  // ----------------------------------------
  reg [11:0] temp [0:2];
  reg [31:0] refresh_cnt;
  reg [7:0] temp_hi [0:2];
  reg pg_q;
  wire pg_rise = main_power_good & ~pg_q;
  // sample all zones on one counter so high bytes and low bits stay coherent
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      refresh_cnt <= 32'h00000000;
      temp[0] <= 12'h000;
      temp[1] <= 12'h000;
      temp[2] <= 12'h000;
    end else if (clk_en) begin
      if (refresh_cnt >= REFRESH_CYC - 1) begin
        refresh_cnt <= 32'h00000000;
        temp[0] <= first_diode_fault ? {`HWMR_TEMP_FAULT, 4'h0} : first_remote_reading;
        temp[1] <= ambient_reading;
        temp[2] <= second_diode_fault ? {`HWMR_TEMP_FAULT, 4'h0} : second_remote_reading;
      end else begin
        refresh_cnt <= refresh_cnt + 32'h00000001;
      end
    end
  end
  // ----------------------------------------
  // 90 kHz time base
  // ----------------------------------------
  reg [15:0] tick_cnt;
  wire tick = (tick_cnt == TICK_DIV - 1);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= 16'h0000;
      pg_q <= 1'b0;
    end else if (clk_en) begin
      pg_q <= main_power_good;
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire req = wb_cyc_i & wb_stb_i;
  reg ack;
  wire take = req & ~ack & clk_en;
  wire rd = take & ~wb_we_i;
  wire wr = take & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack;
  // ----------------------------------------
  // per-fan tach and pwm
  // ----------------------------------------
  wire [15:0] period_view [0:2];
  wire [7:0] duty_view [0:2];
  genvar f;
  generate
    for (f = 0; f < 3; f = f + 1) begin : fan
      reg [1:0] tsync;
      reg tprev;
      reg half;
      reg [15:0] run_cnt;
      reg run_ovf;
      reg [31:0] stall_cnt;
      reg [15:0] period;
      reg [7:0] frozen;
      reg low_frozen;
      reg high_frozen;
      reg [7:0] shadow;
      reg [7:0] duty_now;
      reg [7:0] pwm_cnt;
      wire edge_in = tsync[1] & ~tprev;
      wire [7:0] target;
      wire pwm_manual = manual_mode[f] & start;
      wire hit_lo = rd & (wb_adr_i == `HWMR_FAN1_LOW + 2 * f);
      wire hit_hi = rd & (wb_adr_i == `HWMR_FAN1_LOW + 2 * f + 1);
      // tach: measured on every clk_en cycle; start, manual_mode and ramp_enable play no part
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          // idle tach rests high at its pull-up; resetting high avoids a false edge
          tsync <= 2'h3;
          tprev <= 1'b1;
          half <= 1'b0;
          run_cnt <= 16'h0000;
          run_ovf <= 1'b0;
          stall_cnt <= 32'h00000000;
          period <= `HWMR_ALL_ONES16;
        end else if (clk_en) begin
          tsync <= {tsync[0], tach_in[f]};
          tprev <= tsync[1];
          if (pg_rise) begin
            period <= `HWMR_ALL_ONES16;
            half <= 1'b0;
            run_cnt <= 16'h0000;
            run_ovf <= 1'b0;
            stall_cnt <= 32'h00000000;
          end else begin
            if (tick & ~run_ovf) begin
              if (run_cnt == `HWMR_ALL_ONES16) run_ovf <= 1'b1;
              else run_cnt <= run_cnt + 16'h0001;
            end
            if (edge_in) begin
              half <= ~half;
              if (half) begin
                period <= run_ovf ? `HWMR_ALL_ONES16 : run_cnt;
                run_cnt <= 16'h0000;
                run_ovf <= 1'b0;
                stall_cnt <= 32'h00000000;
              end
            end else if (stall_cnt >= TACH_UPD_CYC - 1) begin
              period <= `HWMR_ALL_ONES16;
              stall_cnt <= 32'h00000000;
            end else begin
              stall_cnt <= stall_cnt + 32'h00000001;
            end
          end
        end
      end
      // byte freeze: reading one half holds the other until it is read
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          frozen <= 8'h00;
          low_frozen <= 1'b0;
          high_frozen <= 1'b0;
        end else if (clk_en) begin
          if (hit_lo & ~low_frozen) begin
            frozen <= period[15:8];
            high_frozen <= 1'b1;
          end else if (hit_hi & ~high_frozen) begin
            frozen <= period[7:0];
            low_frozen <= 1'b1;
          end else if (hit_lo | hit_hi) begin
            low_frozen <= 1'b0;
            high_frozen <= 1'b0;
          end
        end
      end
      assign period_view[f] = {high_frozen ? frozen : period[15:8],
                               low_frozen ? frozen : period[7:0]};
      // duty: shadow write, readback loads at period start
      assign target = ~start ? `HWMR_ALL_ONES8 :
                      pwm_manual ? shadow : auto_duty[8*f+7:8*f];
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          shadow <= `HWMR_ALL_ONES8;
          duty_now <= `HWMR_ALL_ONES8;
          pwm_cnt <= 8'h00;
        end else if (clk_en) begin
          if (wr & (wb_adr_i == `HWMR_PWM1_DUTY + f) & ~lock) begin
            shadow <= wb_dat_i[7:0];
          end
          pwm_cnt <= (pwm_cnt == `HWMR_PWM_STEPS) ? 8'h00 : pwm_cnt + 8'h01;
          if (pwm_cnt == `HWMR_PWM_STEPS) duty_now <= target;
        end
      end
      // high while count below duty; FFh leaves one low clock per 256
      assign pwm_out[f] = (pwm_cnt < duty_now);
      assign duty_view[f] = spin_up[f] ? 8'h00 : duty_now;
    end
  endgenerate
  // ----------------------------------------
  // read mux and ack
  // ----------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (wb_adr_i)
      `HWMR_ZONE1_TEMP: next_rdata = temp[0][11:4];
      `HWMR_ZONE2_TEMP: next_rdata = temp[1][11:4];
      `HWMR_ZONE3_TEMP: next_rdata = temp[2][11:4];
      `HWMR_FAN1_LOW: next_rdata = period_view[0][7:0];
      `HWMR_FAN1_HIGH: next_rdata = period_view[0][15:8];
      `HWMR_FAN2_LOW: next_rdata = period_view[1][7:0];
      `HWMR_FAN2_HIGH: next_rdata = period_view[1][15:8];
      `HWMR_FAN3_LOW: next_rdata = period_view[2][7:0];
      `HWMR_FAN3_HIGH: next_rdata = period_view[2][15:8];
      `HWMR_PWM1_DUTY: next_rdata = duty_view[0];
      `HWMR_PWM2_DUTY: next_rdata = duty_view[1];
      `HWMR_PWM3_DUTY: next_rdata = duty_view[2];
      `HWMR_LOWBITS1: next_rdata = {temp[2][3:0], temp[0][3:0]};
      `HWMR_LOWBITS2: next_rdata = {4'h0, temp[1][3:0]};
      `HWMR_CTRL: next_rdata = {6'h00, lock, start};
      `HWMR_FAN_MODE: next_rdata = {1'b0, ramp_enable, 1'b0, manual_mode};
      default: next_rdata = 8'h00;
    endcase
  end
  reg [7:0] dout;
  // temperature and status addresses take no write; the ack still comes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      dout <= 8'h00;
    end else if (clk_en) begin
      ack <= req & ~ack;
      if (rd) dout <= next_rdata;
    end
  end
  assign wb_dat_o = {24'h000000, dout};
endmodule
`default_nettype wire

// *** tb/hwmr_reading_regs_properties.sv ***
// port-level checks for the monitor reading block
`default_nettype none
module hwmr_reading_regs_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic start,
  input wire logic [2:0] pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // helper and assertions
  // ------------------------------
  logic [9:0] quiet;
  // full duty is only sure once a stale duty has had two periods to drain
  always @(posedge clk or posedge reset) begin
    if (reset || start) quiet <= 10'h0;
    else if (quiet != 10'h258) quiet <= quiet + 10'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_width_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper data bits set");
  data_hold_a: assert property (!wb_ack_o |=> wb_ack_o || $stable(wb_dat_o))
    else $error("read data moved");
  pwm_low_one_a: assert property (quiet == 10'h258 && !pwm_out[0] |=> pwm_out[0])
    else $error("pwm low too long");
  pwm_high_run_a: assert property (quiet == 10'h258 && $rose(pwm_out[1]) |-> pwm_out[1][*8])
    else $error("pwm high too short");
  pwm_period_a: assert property (quiet == 10'h258 && $fell(pwm_out[2]) |->
    ##256 ($fell(pwm_out[2]) || start))
    else $error("pwm period wrong");
  cover property (wb_ack_o && wb_dat_o != 32'h0);
  cover property (quiet == 10'h258 && $fell(pwm_out[0]));
  cover property ($rose(start));
endmodule
`default_nettype wire

// *** tb/hwmr_fan_model.sv ***
// behavioural fan tachometer sources
`default_nettype none
module hwmr_fan_model (
  input wire logic clk,
  input wire logic [35:0] gap,
  output logic [2:0] tach_in = 3'h7
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // square waves
  // ------------------------------
  logic [11:0] cnt [3] = '{12'h0, 12'h0, 12'h0};
  // a gap field is half a pulse period; four halves make one revolution
  always @(posedge clk) begin
    for (int f = 0; f < 3; f++) begin
      if (gap[12*f +: 12] == 12'h0) begin
        cnt[f] <= 12'h0;
        tach_in[f] <= 1'b1; // stopped fan rests at the pull-up
      end else if (cnt[f] >= gap[12*f +: 12] - 12'h1) begin
        cnt[f] <= 12'h0;
        tach_in[f] <= ~tach_in[f];
      end else begin
        cnt[f] <= cnt[f] + 12'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/hwmr_reading_regs_tb_top.sv ***
// self-checking bench for the monitor reading registers
`default_nettype none
module hwmr_reading_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // stimulus and checking
  // ------------------------------
  logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, we = 1'b0, ack, start = 1'b0, lock = 1'b0;
  logic main_power_good = 1'b0, fault = 1'b0, fault2 = 1'b0, en = 1'b1;
  logic [2:0] pwm_seen;
  logic [2:0] manual = 3'h0, ramp = 3'h0, spin = 3'h0, tach, pwm;
  logic [7:0] adr = 8'h0;
  logic [15:0] e;
  logic [15:0] q [$];
  logic [31:0] dat = 32'h0, dat_o;
  logic [35:0] gap = 36'h0;
  logic [63:0] rv = 64'h0;
  int seed = 32'h411F6B2A;
  int num_checks = 0;
  int mismatches = 0;
  initial forever #4 clk = ~clk;
  hwmr_fan_model u_fan (.clk(clk), .gap(gap), .tach_in(tach));
  hwmr_reading_regs #(.REFRESH_CYC(50), .TACH_UPD_CYC(2000), .TICK_DIV(4)) u_dut (
    .clk(clk), .reset(reset), .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .first_remote_reading(rv[11:0]), .ambient_reading(rv[23:12]),
    .second_remote_reading(rv[35:24]), .first_diode_fault(fault), .second_diode_fault(fault2),
    .tach_in(tach), .main_power_good(main_power_good), .manual_mode(manual),
    .ramp_enable(ramp), .start(start), .lock(lock), .auto_duty(rv[63:40]), .spin_up(spin),
    .pwm_out(pwm));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    cyc <= 1'b0;
    we <= 1'b0;
    if (n >= 64) begin
      mismatches++;
      give_verdict();
    end
    @(posedge clk);
  endtask
  // a read notes its accepted range; tach counts may slip by one tick
  task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    q.push_back({hi, lo});
    bus(a, 1'b0, 8'h0);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      chk((dat_o >= e[7:0] && dat_o <= e[15:8]) ? {24'h0, e[7:0]} : dat_o, {24'h0, e[7:0]});
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    main_power_good <= 1'b1;
    for (int a = 8'h28; a <= 8'h32; a++) begin
      rd(a[7:0], (a < 8'h2E || a > 8'h2F) ? 8'hFF : 8'h0, (a < 8'h2E || a > 8'h2F) ? 8'hFF : 8'h0);
    end
    $display("reset values done");
    rv <= {$random(seed), $random(seed)};
    fault <= 1'b1;
    repeat (100) @(posedge clk);
    rd(8'h25, 8'h80, 8'h80);
    rd(8'h27, rv[35:28], rv[35:28]);
    rd(8'h26, rv[23:16], rv[23:16]);
    bus(8'h25, 1'b1, 8'h5A);
    rd(8'h25, 8'h80, 8'h80);
    rd(8'h85, {rv[27:24], 4'h0}, {rv[27:24], 4'h0});
    rd(8'h86, {4'h0, rv[15:12]}, {4'h0, rv[15:12]});
    fault2 <= 1'b1;
    repeat (100) @(posedge clk);
    rd(8'h27, 8'h80, 8'h80);
    rd(8'h85, 8'h00, 8'h00);
    $display("temperatures done");
    gap <= {12'h0, 12'h028, 12'h014};
    repeat (5000) @(posedge clk);
    rd(8'h2A, 8'h27, 8'h29);
    rd(8'h2B, 8'h0, 8'h0);
    rd(8'h2C, 8'hFF, 8'hFF);
    rd(8'h2D, 8'hFF, 8'hFF);
    rd(8'h28, 8'h13, 8'h15);
    // a revolution must stay shorter than the stall window, or the count reads all ones
    gap[11:0] <= 12'h12C;
    repeat (5000) @(posedge clk);
    rd(8'h29, 8'h0, 8'h0);
    rd(8'h28, 8'h2B, 8'h2D);
    rd(8'h29, 8'h1, 8'h1);
    $display("tach done");
    manual <= 3'h1;
    ramp <= 3'h6;
    bus(8'h30, 1'b1, 8'h40);
    rd(8'h30, 8'hFF, 8'hFF);
    spin <= 3'h4;
    start <= 1'b1;
    repeat (600) @(posedge clk);
    rd(8'h30, 8'h40, 8'h40);
    rd(8'h31, rv[55:48], rv[55:48]);
    rd(8'h32, 8'h0, 8'h0);
    bus(8'h30, 1'b1, rv[39:32]);
    repeat (600) @(posedge clk);
    rd(8'h30, rv[39:32], rv[39:32]);
    lock <= 1'b1;
    bus(8'h30, 1'b1, ~rv[39:32]);
    repeat (600) @(posedge clk);
    rd(8'h30, rv[39:32], rv[39:32]);
    $display("duty done");
    // clock enable low must freeze the pwm counters
    en <= 1'b0;
    @(posedge clk);
    pwm_seen = pwm;
    repeat (20) @(posedge clk);
    chk({29'h0, pwm}, {29'h0, pwm_seen});
    en <= 1'b1;
    @(posedge clk);
    $display("clock enable done");
    give_verdict();
  end
endmodule
bind hwmr_reading_regs hwmr_reading_regs_properties u_chk (.clk(clk), .reset(reset),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .start(start), .pwm_out(pwm_out));
`default_nettype wire
